// File: src/irq_ident_pkg.sv
// Constants shared by the interrupt identification block.
package irq_ident_pkg;
  // Register byte offsets.
  localparam logic [7:0] VEC_OFF = 8'h00;
  localparam logic [7:0] SYS_ID_OFF = 8'h04;
  localparam logic [7:0] M1_ID_OFF = 8'h08;
  localparam logic [7:0] M5_ID_OFF = 8'h0c;
  localparam logic [7:0] SRC_FLAG_OFF = 8'h10;
  localparam logic [7:0] SRC_EN_OFF = 8'h14;
  localparam logic [7:0] I2C_FLAG_OFF = 8'h18;
  localparam logic [7:0] I2C_EN_OFF = 8'h1c;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h20;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h24;
  // Widths.
  localparam int ID_W = 16;
  localparam int PIN_N = 7;
  localparam int MOD_N = 6;
  localparam int SYS_W = 7;
  localparam int SRC_W = 12;
  localparam int EN_W = 10;
  // Source flag positions.
  localparam int SVM_BIT = 7;
  localparam int SPI_DONE_BIT = 8;
  localparam int SPI_COL_BIT = 9;
  localparam int SPI_OVR_BIT = 10;
  localparam int SPI_FAULT_BIT = 11;
  // Enable positions.
  localparam int SPI_SHARED_EN_BIT = 8;
  localparam int SPI_FAULT_EN_BIT = 9;
  // Identification bit positions.
  localparam int M1_I2C_BIT = 8;
  localparam int M5_SPI_BIT = 0;
  localparam int SYS_SHARED_BIT = 6;
  // Reset values.
  localparam logic [15:0] VEC_RST = 16'h0000;
  localparam logic [15:0] ID_RST = 16'h0000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
endpackage : irq_ident_pkg

// File: src/irq_ident.sv
// Interrupt flag latching, module identification and vector register with an APB slave.
//
// Overview of operation
// - Every source flag is set by its event no matter how any enable is programmed.
// - A flag stays set until software writes a one to clear it, so an enabled flag keeps its module pending bit set; irq drops after a status read.
// - All interrupts point the core at the one address held in the vector register.
// - The system identification register has one pending bit per module plus one system bit.
// - The vector register is zero after reset.
// - The vector register accepts any program address that software writes.
// - There are six modules; identification registers exist only for modules one and five.
// - Identification registers are sixteen bits, read-only, and zero after reset.
// - Each identification bit is the OR of a function's flags each ANDed with its enable.
// - Module one bit 8 combines all enabled I2C host status conditions.
// - Module one bit 7 shows an enabled supply monitor interrupt.
// - Module one bits 6 to 0 show enabled external interrupts on port six pins 6 to 0.
// - Module one bits 15 to 9 always read zero.
// - SPI done, collision and overrun flags share one enable.
// - The SPI fault flag has its own enable.
// - The individual flag bits stay readable on their own.
`timescale 1ns/100ps
module irq_ident
  import irq_ident_pkg::*;
#(
  parameter int I2C_N = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PIN_N-1:0] port6_pin,
  input wire logic supply_monitor_event,
  input wire logic [I2C_N-1:0] i2c_host_event,
  input wire logic spi_host_done_event,
  input wire logic spi_host_collision_event,
  input wire logic spi_host_overrun_event,
  input wire logic spi_host_fault_event,
  input wire logic [MOD_N-1:0] other_module_pending,
  input wire logic system_pending,
  output logic [15:0] service_vector,
  output logic [SYS_W-1:0] module_pending,
  output logic irq
);

  logic [15:0] service_vector_reg_q;
  logic [SRC_W-1:0] src_flag_q;
  logic [EN_W-1:0] src_en_q;
  logic [I2C_N-1:0] i2c_host_status_reg_q;
  logic [I2C_N-1:0] i2c_en_q;
  logic [SYS_W-1:0] irq_stat_q;
  logic [SYS_W-1:0] irq_mask_q;
  logic [SYS_W-1:0] pend_prev_q;
  logic [PIN_N-1:0] pin_s1_q;
  logic [PIN_N-1:0] pin_s2_q;
  logic [PIN_N-1:0] pin_s3_q;
  logic [SRC_W-1:0] src_set;
  logic [ID_W-1:0] module_one_source_flags;
  logic [ID_W-1:0] module_five_source_flags;
  logic [SYS_W-1:0] system_source_id_reg;
  logic [SYS_W-1:0] stat_set;
  logic [31:0] rdata_d;
  logic i2c_host_pending;
  logic supply_monitor_pending;
  logic spi_host_pending;
  logic setup;
  logic access;
  logic wr;
  logic rd_stat;
  logic mapped;

  // Bus phase decode; the slave answers in the first access cycle.
  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign wr = access && pwrite;
  assign rd_stat = access && !pwrite && (paddr == IRQ_STAT_OFF);

  // Port six pins are asynchronous and pass two flip-flops first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
    end else begin
      pin_s1_q <= port6_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // Event vector in the source flag layout; a rising pin is an event.
  always_comb begin
    src_set = '0;
    src_set[PIN_N-1:0] = pin_s2_q & ~pin_s3_q;
    src_set[SVM_BIT] = supply_monitor_event;
    src_set[SPI_DONE_BIT] = spi_host_done_event;
    src_set[SPI_COL_BIT] = spi_host_collision_event;
    src_set[SPI_OVR_BIT] = spi_host_overrun_event;
    src_set[SPI_FAULT_BIT] = spi_host_fault_event;
  end

  // Source flags latch regardless of enables; a write of one clears, the event wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_flag_q <= '0;
    end else if (wr && paddr == SRC_FLAG_OFF) begin
      src_flag_q <= (src_flag_q & ~pwdata[SRC_W-1:0]) | src_set;
    end else begin
      src_flag_q <= src_flag_q | src_set;
    end
  end

  // I2C host status flags behave the same way.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      i2c_host_status_reg_q <= '0;
    end else if (wr && paddr == I2C_FLAG_OFF) begin
      i2c_host_status_reg_q <= (i2c_host_status_reg_q & ~pwdata[I2C_N-1:0]) | i2c_host_event;
    end else begin
      i2c_host_status_reg_q <= i2c_host_status_reg_q | i2c_host_event;
    end
  end

  // Enable registers, written directly by software.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_en_q <= '0;
      i2c_en_q <= '0;
    end else if (wr) begin
      if (paddr == SRC_EN_OFF) begin
        src_en_q <= pwdata[EN_W-1:0];
      end
      if (paddr == I2C_EN_OFF) begin
        i2c_en_q <= pwdata[I2C_N-1:0];
      end
    end
  end

  // Vector register takes any address and starts at zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      service_vector_reg_q <= VEC_RST;
    end else if (wr && paddr == VEC_OFF) begin
      service_vector_reg_q <= pwdata[15:0];
    end
  end

  // Function pending terms: flags ANDed with their enables, then ORed.
  assign i2c_host_pending = |(i2c_host_status_reg_q & i2c_en_q);
  assign supply_monitor_pending = src_flag_q[SVM_BIT] && src_en_q[SVM_BIT];
  assign spi_host_pending = (src_en_q[SPI_SHARED_EN_BIT] && (src_flag_q[SPI_DONE_BIT]
    || src_flag_q[SPI_COL_BIT] || src_flag_q[SPI_OVR_BIT]))
    || (src_en_q[SPI_FAULT_EN_BIT] && src_flag_q[SPI_FAULT_BIT]);

  // Module identification words; unused bits stay zero.
  always_comb begin
    module_one_source_flags = ID_RST;
    module_one_source_flags[PIN_N-1:0] = src_flag_q[PIN_N-1:0] & src_en_q[PIN_N-1:0];
    module_one_source_flags[SVM_BIT] = supply_monitor_pending;
    module_one_source_flags[M1_I2C_BIT] = i2c_host_pending;
    module_five_source_flags = ID_RST;
    module_five_source_flags[M5_SPI_BIT] = spi_host_pending;
  end

  // System identification: one bit per module and one shared system bit.
  always_comb begin
    system_source_id_reg = '0;
    system_source_id_reg[MOD_N-1:0] = other_module_pending;
    system_source_id_reg[1] = other_module_pending[1] || (|module_one_source_flags);
    system_source_id_reg[5] = other_module_pending[5] || (|module_five_source_flags);
    system_source_id_reg[SYS_SHARED_BIT] = system_pending;
  end

  // Pending outputs and the vector the core jumps to.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      module_pending <= '0;
      service_vector <= VEC_RST;
      pend_prev_q <= '0;
    end else begin
      module_pending <= system_source_id_reg;
      service_vector <= service_vector_reg_q;
      pend_prev_q <= system_source_id_reg;
    end
  end

  // Sticky status sets on a rising pending bit; a read clears only the bits it reported, and a set wins.
  assign stat_set = system_source_id_reg & ~pend_prev_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
    end else if (rd_stat) begin
      irq_stat_q <= (irq_stat_q & ~prdata[SYS_W-1:0]) | stat_set;
    end else begin
      irq_stat_q <= irq_stat_q | stat_set;
    end
  end

  // Mask register of the status layout.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= '0;
    end else if (wr && paddr == IRQ_MASK_OFF) begin
      irq_mask_q <= pwdata[SYS_W-1:0];
    end
  end

  // Level interrupt output from the masked status.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Read multiplexer; flag words stay visible apart from the identification words.
  always_comb begin
    rdata_d = WORD_RST;
    mapped = 1'b1;
    unique case (paddr)
      VEC_OFF: rdata_d[15:0] = service_vector_reg_q;
      SYS_ID_OFF: rdata_d[SYS_W-1:0] = system_source_id_reg;
      M1_ID_OFF: rdata_d[ID_W-1:0] = module_one_source_flags;
      M5_ID_OFF: rdata_d[ID_W-1:0] = module_five_source_flags;
      SRC_FLAG_OFF: rdata_d[SRC_W-1:0] = src_flag_q;
      SRC_EN_OFF: rdata_d[EN_W-1:0] = src_en_q;
      I2C_FLAG_OFF: rdata_d[I2C_N-1:0] = i2c_host_status_reg_q;
      I2C_EN_OFF: rdata_d[I2C_N-1:0] = i2c_en_q;
      IRQ_STAT_OFF: rdata_d[SYS_W-1:0] = irq_stat_q;
      IRQ_MASK_OFF: rdata_d[SYS_W-1:0] = irq_mask_q;
      default: mapped = 1'b0;
    endcase
  end

  // APB answer: ready, data and error all registered in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= WORD_RST;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      prdata <= (setup && !pwrite) ? rdata_d : WORD_RST;
      pslverr <= setup && !mapped;
    end
  end

  // Checks.
  sequence s_wr_vec;
    wr && paddr == VEC_OFF;
  endsequence

  sequence s_vec_out;
    ##2 service_vector == 16'($past(pwdata, 2));
  endsequence

  property p_vec_load;
    @(posedge pclk) disable iff (!presetn) s_wr_vec |-> s_vec_out;
  endproperty
  a_vec_load: assert property (p_vec_load) else $error("vector output did not follow write");

  property p_vec_reset;
    @(posedge pclk) $rose(presetn) |-> service_vector_reg_q == VEC_RST;
  endproperty
  a_vec_reset: assert property (p_vec_reset) else $error("vector not zero after reset");

  property p_flag_set;
    @(posedge pclk) disable iff (!presetn) supply_monitor_event |=> src_flag_q[SVM_BIT];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("supply flag not set by event");

  property p_flag_hold;
    @(posedge pclk) disable iff (!presetn)
      src_flag_q[SVM_BIT] && !(wr && paddr == SRC_FLAG_OFF) |=> src_flag_q[SVM_BIT];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without clear");

  property p_m1_upper;
    @(posedge pclk) disable iff (!presetn)
      access && !pwrite && paddr == M1_ID_OFF |-> prdata[31:M1_I2C_BIT+1] == '0;
  endproperty
  a_m1_upper: assert property (p_m1_upper) else $error("module one upper bits nonzero");

  property p_i2c_bit;
    @(posedge pclk) disable iff (!presetn)
      module_one_source_flags[M1_I2C_BIT] == (|(i2c_host_status_reg_q & i2c_en_q));
  endproperty
  a_i2c_bit: assert property (p_i2c_bit) else $error("i2c identification bit wrong");

  property p_spi_fault;
    @(posedge pclk) disable iff (!presetn)
      src_flag_q[SPI_FAULT_BIT] && src_en_q[SPI_FAULT_EN_BIT] |-> module_five_source_flags[M5_SPI_BIT];
  endproperty
  a_spi_fault: assert property (p_spi_fault) else $error("spi fault not identified");

  property p_spi_shared;
    @(posedge pclk) disable iff (!presetn)
      !src_en_q[SPI_SHARED_EN_BIT] && !src_flag_q[SPI_FAULT_BIT] |-> !module_five_source_flags[M5_SPI_BIT];
  endproperty
  a_spi_shared: assert property (p_spi_shared) else $error("spi shared enable ignored");

  property p_pin_bits;
    @(posedge pclk) disable iff (!presetn)
      module_one_source_flags[PIN_N-1:0] == (src_flag_q[PIN_N-1:0] & src_en_q[PIN_N-1:0]);
  endproperty
  a_pin_bits: assert property (p_pin_bits) else $error("port six identification wrong");

  property p_sys_m1;
    @(posedge pclk) disable iff (!presetn)
      (|module_one_source_flags) |=> module_pending[1];
  endproperty
  a_sys_m1: assert property (p_sys_m1) else $error("module one pending missing");

  // Interrupt path: a masked status bit raises the level output one cycle later.
  sequence s_stat_masked;
    |(irq_stat_q & irq_mask_q);
  endsequence

  sequence s_irq_high;
    ##1 irq;
  endsequence

  property p_irq_raise;
    @(posedge pclk) disable iff (!presetn) s_stat_masked |-> s_irq_high;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("masked status did not raise irq");

  property p_irq_drop;
    @(posedge pclk) disable iff (!presetn) !(|(irq_stat_q & irq_mask_q)) |=> !irq;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("irq high without masked status");

  property p_stat_hold;
    @(posedge pclk) disable iff (!presetn)
      !rd_stat |=> (irq_stat_q & $past(irq_stat_q)) == $past(irq_stat_q);
  endproperty
  a_stat_hold: assert property (p_stat_hold) else $error("status bit dropped without read");

  property p_stat_clear;
    @(posedge pclk) disable iff (!presetn)
      rd_stat && stat_set == '0 |=> (irq_stat_q & SYS_W'($past(prdata))) == '0;
  endproperty
  a_stat_clear: assert property (p_stat_clear) else $error("status read did not clear reported bits");

  property p_stat_event;
    @(posedge pclk) disable iff (!presetn)
      stat_set != '0 |=> (irq_stat_q & $past(stat_set)) == $past(stat_set);
  endproperty
  a_stat_event: assert property (p_stat_event) else $error("status event lost");

  property p_ready_pulse;
    @(posedge pclk) disable iff (!presetn) pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");

  property p_err_ready;
    @(posedge pclk) disable iff (!presetn) pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");

  property p_rdata_idle;
    @(posedge pclk) disable iff (!presetn) !pready |-> prdata == WORD_RST;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer cycle");

  property p_id_reset;
    @(posedge pclk) $rose(presetn) |->
      module_one_source_flags == ID_RST && module_five_source_flags == ID_RST;
  endproperty
  a_id_reset: assert property (p_id_reset) else $error("identification not zero after reset");

  property p_sys_shared;
    @(posedge pclk) disable iff (!presetn) system_pending |=> module_pending[SYS_SHARED_BIT];
  endproperty
  a_sys_shared: assert property (p_sys_shared) else $error("system pending bit missing");

  property p_pin_event;
    @(posedge pclk) disable iff (!presetn)
      (pin_s2_q & ~pin_s3_q) != '0 |=>
      (src_flag_q[PIN_N-1:0] & $past(pin_s2_q) & ~$past(pin_s3_q)) == ($past(pin_s2_q) & ~$past(pin_s3_q));
  endproperty
  a_pin_event: assert property (p_pin_event) else $error("pin edge did not set its flag");

endmodule : irq_ident

// File: verif/irq_handler_model.sv
// Behavioural core interrupt handler that vectors on each new interrupt request.
`timescale 1ns/100ps
module irq_handler_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic irq,
  input wire logic [15:0] service_vector,
  output logic taken,
  output logic [15:0] taken_vec
);
  logic irq_q;
  // A rising request makes the core jump to the one address in the vector register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
      taken <= 1'b0;
      taken_vec <= 16'h0000;
    end else begin
      irq_q <= irq;
      taken <= irq && !irq_q;
      if (irq && !irq_q) begin
        taken_vec <= service_vector;
      end
    end
  end
endmodule : irq_handler_model

// File: verif/irq_ident_tb.sv
// Self-checking bench for the interrupt identification block.
`timescale 1ns/100ps
module irq_ident_tb;
  import irq_ident_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, irq, taken, sup = 1'b0, sd = 1'b0, sc = 1'b0, so = 1'b0, sf = 1'b0, sysp = 1'b0;
  logic [6:0] pins = 7'h00, modp;
  logic [7:0] i2c = 8'h00;
  logic [5:0] oth = 6'h00;
  logic [15:0] svec, tvec, v;
  logic [32:0] q[$];
  logic [15:0] vq[$];
  int err_count = 0, n_checks = 0, cyc = 0;
  logic [6:0] p;
  irq_ident #(.I2C_N(8)) irq_ident_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port6_pin(pins), .supply_monitor_event(sup), .i2c_host_event(i2c), .spi_host_done_event(sd),
    .spi_host_collision_event(sc), .spi_host_overrun_event(so), .spi_host_fault_event(sf),
    .other_module_pending(oth), .system_pending(sysp), .service_vector(svec), .module_pending(modp), .irq(irq));
  irq_handler_model irq_handler_model_inst (.pclk(pclk), .presetn(presetn), .irq(irq),
    .service_vector(svec), .taken(taken), .taken_vec(tvec));
  // Clock of 5 ns period.
  always #2.5 pclk = ~pclk;
  // Cuts a hung run short.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      results();
    end
  end
  // Compares each completed read and each vectoring against the oldest note.
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      n_checks++;
      if ({pslverr, prdata} !== q[0]) begin
        err_count++;
        $display("[ERR] %0t read %h got %h exp %h", $time, paddr, {pslverr, prdata}, q[0]);
      end
      void'(q.pop_front());
    end
    if (taken === 1'b1) begin
      n_checks++;
      if (vq.size() == 0 || tvec !== vq[0]) begin
        err_count++;
        $display("[ERR] %0t vector %h", $time, tvec);
      end
      if (vq.size() != 0) void'(vq.pop_front());
    end
  end
  // One APB transfer; reads note their expected error flag and data first.
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    if (!w) q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xf
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xf(1'b1, a, d, 33'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    xf(1'b0, a, 32'h0, e);
  endtask : rd
  // Prints the verdict and ends the run.
  task automatic results();
    if (err_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  // Main sequence.
  initial begin
    void'($urandom(32'h870a));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(VEC_OFF, 33'h0);
    rd(M1_ID_OFF, 33'h0);
    rd(M5_ID_OFF, 33'h0);
    rd(SYS_ID_OFF, 33'h0);
    rd(8'h30, 33'h1_0000_0000);
    v = 16'($urandom);
    wr(VEC_OFF, {16'h0, v});
    rd(VEC_OFF, {17'h0, v});
    wr(IRQ_MASK_OFF, 32'h2);
    @(posedge pclk) sup <= 1'b1;
    @(posedge pclk) sup <= 1'b0;
    rd(SRC_FLAG_OFF, 33'h80);
    rd(M1_ID_OFF, 33'h0);
    vq.push_back(v);
    wr(SRC_EN_OFF, 32'h80);
    rd(M1_ID_OFF, 33'h80);
    rd(SYS_ID_OFF, 33'h2);
    rd(SRC_FLAG_OFF, 33'h80);
    rd(IRQ_STAT_OFF, 33'h2);
    rd(IRQ_STAT_OFF, 33'h0);
    wr(IRQ_MASK_OFF, 32'h0);
    wr(SRC_FLAG_OFF, 32'h80);
    rd(M1_ID_OFF, 33'h0);
    p = 7'($urandom % 127) + 7'h1;
    pins <= p;
    repeat (6) @(posedge pclk);
    rd(SRC_FLAG_OFF, {26'h0, p});
    wr(SRC_EN_OFF, {25'h0, p});
    rd(M1_ID_OFF, {26'h0, p});
    wr(SRC_FLAG_OFF, 32'h7f);
    pins <= 7'h00;
    @(posedge pclk) i2c <= 8'h81;
    @(posedge pclk) i2c <= 8'h00;
    wr(I2C_EN_OFF, 32'h80);
    rd(M1_ID_OFF, 33'h100);
    rd(I2C_FLAG_OFF, 33'h81);
    wr(SRC_EN_OFF, 32'h100);
    @(posedge pclk) begin
      sc <= 1'b1;
      sf <= 1'b1;
    end
    @(posedge pclk) begin
      sc <= 1'b0;
      sf <= 1'b0;
    end
    rd(M5_ID_OFF, 33'h1);
    wr(SRC_FLAG_OFF, 32'h200);
    rd(M5_ID_OFF, 33'h0);
    wr(SRC_EN_OFF, 32'h200);
    rd(M5_ID_OFF, 33'h1);
    rd(SRC_FLAG_OFF, 33'h800);
    oth <= 6'h08;
    sysp <= 1'b1;
    rd(SYS_ID_OFF, 33'h6a);
    n_checks++;
    if (modp !== 7'h6a) begin
      err_count++;
      $display("[ERR] %0t module pending %h", $time, modp);
    end
    rd(M1_ID_OFF, 33'h100);
    n_checks++;
    if (vq.size() != 0) begin
      err_count++;
      $display("[ERR] %0t vector never taken", $time);
    end
    results();
  end
endmodule : irq_ident_tb
